// ===== testbench/dli_ctrl_model.sv
// Controller side of the event port: logs every reported event by code
module dli_ctrl_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic evt_valid_in,
  input wire logic [3:0] evt_code_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [14];
  // Tally per code; codes above the table are dropped, not wrapped
  always @(posedge clk_sys_in)
  begin
    if (rst_in || clr_in)
      foreach (cnt[i]) cnt[i] <= 0;
    else if (evt_valid_in && evt_code_in < 4'he)
      cnt[evt_code_in] <= cnt[evt_code_in] + 1;
  end
endmodule

// ===== testbench/test_dli_event_gen.sv
`include "dli_defs.svh"
module test_dli_event_gen;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic btn = 1'b0;
  logic occ = 1'b0;
  logic mov = 1'b0;
  logic clr = 1'b0;
  logic [7:0] pos = 8'h00;
  logic [31:0] rdo;
  logic wrq;
  logic irq;
  logic idn;
  logic ev;
  logic [3:0] evc;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;

  // Fast tick so that second-scale timers fit the run
  dli_event_gen #(.CYC_PER_MS(10)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wrq), .button_in(btn), .position_in(pos),
    .occupied_in(occ), .movement_in(mov), .irq_out(irq), .identify_out(idn),
    .evt_valid_out(ev), .evt_code_out(evc)
  );
  dli_ctrl_model model_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clr_in(clr),
    .evt_valid_in(ev), .evt_code_in(evc)
  );

  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard: whole sequence needs about 52000 cycles
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      errors = errors + 1;
      complete_run;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_sys_in); while (wrq !== 1'b0);
    rdat = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask

  task automatic cchk(input string n, input int code, input int e);
    chk(n, e, model_u.cnt[code]);
  endtask

  task automatic ms(input int n);
    repeat (n * 10) @(posedge clk_sys_in);
  endtask

  task automatic setb(input logic v, input int n);
    @(posedge clk_sys_in);
    btn <= v;
    ms(n);
  endtask

  // New test: program enables, drop old status and counts
  task automatic begin_test(input logic [31:0] c);
    bus(1'b1, `DLI_REG_CTRL, c);
    bus(1'b1, `DLI_REG_STATUS, 32'h3fff);
    @(posedge clk_sys_in);
    clr <= 1'b1;
    @(posedge clk_sys_in);
    clr <= 1'b0;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Reset values of the timers and an unmapped offset
    rdchk("t_short", `DLI_REG_T_SHORT, 32'h1f4);
    rdchk("t_double", `DLI_REG_T_DOUBLE, 32'hc8);
    rdchk("t_rep", `DLI_REG_T_REP, 32'h64);
    rdchk("t_stuck", `DLI_REG_T_STUCK, 32'h0a);
    rdchk("t_hold", `DLI_REG_T_HOLD, 32'h1);
    rdchk("ctrl", `DLI_REG_CTRL, 32'h0);
    rdchk("unmapped", 6'h3c, 32'h0);
    done("reset");
    // Disabled press and release stay silent
    setb(1'b1, 2);
    setb(1'b0, 2);
    cchk("press off", dli_pkg::DLI_EV_PRESS, 0);
    cchk("release off", dli_pkg::DLI_EV_RELEASE, 0);
    rdchk("status off", `DLI_REG_STATUS, 32'h0);
    begin_test(32'h3);
    bus(1'b1, `DLI_REG_MASK, 32'h1);
    setb(1'b1, 2);
    cchk("press on", dli_pkg::DLI_EV_PRESS, 1);
    chk("irq set", 32'h1, irq);
    setb(1'b0, 2);
    cchk("release on", dli_pkg::DLI_EV_RELEASE, 1);
    bus(1'b1, `DLI_REG_STATUS, 32'h1);
    // The clear lands at the answer edge; look once it has settled
    @(negedge clk_sys_in);
    chk("irq clear", 32'h0, irq);
    rdchk("status w1c", `DLI_REG_STATUS, 32'h2);
    done("press");
    // Short release, long start enabled but not reached
    begin_test(32'h14);
    setb(1'b1, 100);
    // Long pause so this press cannot pair with the next test's first one
    setb(1'b0, 250);
    cchk("short", dli_pkg::DLI_EV_SHORT, 1);
    cchk("no lstart", dli_pkg::DLI_EV_LSTART, 0);
    done("short");
    // Two pairs: 80 ms span counts, 240 ms span exceeds 200 ms
    begin_test(32'h8);
    for (int gap = 40; gap <= 200; gap += 160)
    begin
      setb(1'b1, 20);
      setb(1'b0, gap);
      setb(1'b1, 20);
      setb(1'b0, 250);
      cchk("double", dli_pkg::DLI_EV_DOUBLE, 1);
    end
    done("double");
    // Long hold of 760 ms: start near 500, repeats every 100 ms
    begin_test(32'h70);
    setb(1'b1, 760);
    cchk("lstart", dli_pkg::DLI_EV_LSTART, 1);
    chk("repeats", 32'h1, model_u.cnt[5] inside {2, 3});
    setb(1'b0, 5);
    cchk("lstop", dli_pkg::DLI_EV_LSTOP, 1);
    done("long");
    // Position change held back by 5 ms dead time, then periodic; vacant repeat alongside
    begin_test(32'h4a00);
    bus(1'b1, `DLI_REG_T_PDEAD, 32'h5);
    @(posedge clk_sys_in);
    pos <= 8'h5a;
    ms(4);
    cchk("pos early", dli_pkg::DLI_EV_POS, 0);
    ms(3);
    cchk("pos late", dli_pkg::DLI_EV_POS, 1);
    bus(1'b1, `DLI_REG_T_PREP, 32'h1);
    bus(1'b1, `DLI_REG_T_OREP, 32'h1);
    ms(1100);
    chk("pos report", 32'h1, model_u.cnt[9] >= 2);
    chk("occ repeat", 32'h1, model_u.cnt[11] >= 1);
    bus(1'b1, `DLI_REG_T_PREP, 32'h0);
    bus(1'b1, `DLI_REG_T_OREP, 32'h0);
    done("position");
    // Occupied, vacant, movement on; no-movement off
    begin_test(32'h1c00);
    bus(1'b1, `DLI_REG_T_ODEAD, 32'h2);
    @(posedge clk_sys_in);
    occ <= 1'b1;
    ms(1);
    cchk("occ early", dli_pkg::DLI_EV_OCC, 0);
    ms(5);
    cchk("occ", dli_pkg::DLI_EV_OCC, 1);
    // Movement apart: the one dead-time slot keeps only the newest event
    @(posedge clk_sys_in);
    mov <= 1'b1;
    ms(5);
    cchk("move", dli_pkg::DLI_EV_MOVE, 1);
    @(posedge clk_sys_in);
    occ <= 1'b0;
    mov <= 1'b0;
    ms(100);
    cchk("vac held", dli_pkg::DLI_EV_VAC, 0);
    cchk("nomove off", dli_pkg::DLI_EV_NOMOVE, 0);
    // Vacant waits for the second second-tick after the occupied change
    ms(1950);
    cchk("vac", dli_pkg::DLI_EV_VAC, 1);
    done("occupancy");
    // Identify, then instance search latching the button
    bus(1'b1, `DLI_REG_IDENT, 32'h1);
    @(negedge clk_sys_in);
    chk("identify", 32'h1, idn);
    bus(1'b1, `DLI_REG_IDENT, 32'h2);
    @(negedge clk_sys_in);
    chk("identify off", 32'h0, idn);
    setb(1'b1, 2);
    setb(1'b0, 2);
    bus(1'b0, `DLI_REG_STATE, 32'h0);
    chk("instance", 32'h1, rdat[9:7]);
    done("identify");
    complete_run;
  end
endmodule

// ===== verilog/dli_defs.svh
`ifndef DLI_DEFS_SVH
`define DLI_DEFS_SVH
// Clock and tick timing
`define DLI_CLK_PERIOD_NS 10
`define DLI_NS_PER_MS 1000000
`define DLI_CYC_PER_MS (`DLI_NS_PER_MS / `DLI_CLK_PERIOD_NS)
`define DLI_MS_PER_S 10'h3e8
`define DLI_DIV_W 17
// Register byte offsets
`define DLI_REG_CTRL 6'h00
`define DLI_REG_T_SHORT 6'h04
`define DLI_REG_T_DOUBLE 6'h08
`define DLI_REG_T_REP 6'h0c
`define DLI_REG_T_STUCK 6'h10
`define DLI_REG_T_PREP 6'h14
`define DLI_REG_T_PDEAD 6'h18
`define DLI_REG_T_HOLD 6'h1c
`define DLI_REG_T_OREP 6'h20
`define DLI_REG_T_ODEAD 6'h24
`define DLI_REG_STATUS 6'h28
`define DLI_REG_MASK 6'h2c
`define DLI_REG_STATE 6'h30
`define DLI_REG_IDENT 6'h34
// Reset values
`define DLI_RST_SHORT 13'h01f4
`define DLI_RST_DOUBLE 11'h0c8
`define DLI_RST_REP 11'h064
`define DLI_RST_STUCK 8'h0a
`define DLI_RST_HOLD 12'h001
// Control layout: bit n enables event code n, except code 8 which uses bit 7; extra bits below
`define DLI_CTRL_MASK 15'h7eff
`define DLI_EN_OREP 4'he
`define DLI_IDENT_ON 1'h0
`define DLI_IDENT_TEST 1'h1
// Saturation limits of the counters
`define DLI_LIM_MS 14'h1fff
`define DLI_LIM_DBL 14'h07ff
`define DLI_LIM_S 14'h00ff
`define DLI_LIM_HOLD 14'h0fff
// Instance numbers
`define DLI_INST_BTN 2'h0
`define DLI_INST_POS 2'h1
`define DLI_INST_OCC 2'h2
`endif

// ===== verilog/dli_event_gen.sv
`include "dli_defs.svh"
// Overview of operation
// R1: Press event only while press enable set
// R2: Release event only while release enable set
// R3: Release before short time is short press
// R4: Two short cycles within double time
// R5: Long start/repeat/stop each individually enabled
// R6: Long repeat every repeat interval while held
// R7: Past stuck time: stop long events, stuck
// R8: Position re-reported every report interval
// R9: Position events delayed by dead time
// R10: Occupied and vacant events individually enabled
// R11: Movement and no-movement events individually enabled
// R12: Occupancy state held at least hold time
// R13: Repeat re-sends current occupancy event periodically
// R14: Occupancy events delayed by dead time
// R15: Identify request makes device physically identifiable
// R16: Instance test reports actuated instance number
// R17: Controller uses these only when associated
// R18: All timing from common millisecond tick
// R19: Reset clears timers and classification state
module dli_event_gen #(
  parameter int CYC_PER_MS = `DLI_CYC_PER_MS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic button_in,
  input wire logic [7:0] position_in,
  input wire logic occupied_in,
  input wire logic movement_in,
  output logic irq_out,
  output logic identify_out,
  output logic evt_valid_out,
  output logic [3:0] evt_code_out
);
  dli_pkg::dli_core_type st;
  dli_pkg::dli_core_type nx;
  logic ms_tick;
  logic s_tick;
  logic busy;
  logic take;
  logic press;
  logic rel;
  logic pchg;
  logic ptrig;
  logic otrig;
  dli_pkg::dli_event_type ocode;
  logic [13:0] ev;
  logic [13:0] gated;
  logic [13:0] w1c;

  // Shared time base
  dli_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ms_tick_out(ms_tick),
    .s_tick_out(s_tick)
  );

  // Saturating up-count; saturation keeps long holds from wrapping to short
  function automatic logic [13:0] f_inc(input logic [13:0] v, input logic [13:0] lim, input logic en);
    return (en && v < lim) ? v + 14'h0001 : v;
  endfunction

  // Dead-time count-down, stops at zero
  function automatic logic [13:0] f_dn(input logic [13:0] v, input logic en);
    return (en && v != 14'h0000) ? v - 14'h0001 : v;
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] f_wr(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Per-event enable; free shares the stuck enable
  function automatic logic [13:0] f_en(input logic [14:0] c);
    logic [13:0] e;
    e = c[13:0];
    e[dli_pkg::DLI_EV_FREE] = c[dli_pkg::DLI_EV_STUCK];
    return e;
  endfunction

  // Lowest event code wins the output port; status keeps the rest
  function automatic logic [3:0] f_first(input logic [13:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 13; i >= 0; i--)
    begin
      if (v[i])
      begin
        c = 4'(i);
      end
    end
    return c;
  endfunction

  // Read mux; unmapped addresses read zero
  function automatic logic [31:0] f_rd(input dli_pkg::dli_core_type s, input logic [5:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `DLI_REG_CTRL: r = 32'(s.ctrl);
      `DLI_REG_T_SHORT: r = 32'(s.t_short);
      `DLI_REG_T_DOUBLE: r = 32'(s.t_double);
      `DLI_REG_T_REP: r = 32'(s.t_rep);
      `DLI_REG_T_STUCK: r = 32'(s.t_stuck);
      `DLI_REG_T_PREP: r = 32'(s.t_prep);
      `DLI_REG_T_PDEAD: r = 32'(s.t_pdead);
      `DLI_REG_T_HOLD: r = 32'(s.t_hold);
      `DLI_REG_T_OREP: r = 32'(s.t_orep);
      `DLI_REG_T_ODEAD: r = 32'(s.t_odead);
      `DLI_REG_STATUS: r = 32'(s.status);
      `DLI_REG_MASK: r = 32'(s.mask);
      `DLI_REG_STATE: r = {8'h00, s.pos_prev, 6'h00, s.inst, s.inst_v, s.o_pend, s.pos_pend,
                           s.mov, s.occ, s.btn_prev, s.bst};
      `DLI_REG_IDENT: r = 32'(s.ident);
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Whole next-state computation
  always_comb
  begin
    nx = st;
    ev = '0;
    w1c = '0;
    ptrig = 1'b0;
    otrig = 1'b0;
    ocode = dli_pkg::DLI_EV_OCC;
    busy = avs_read_in | avs_write_in;
    take = busy & st.ack;
    press = button_in & ~st.btn_prev;
    rel = ~button_in & st.btn_prev;
    pchg = (position_in != st.pos_prev);

    // Button counters run on the millisecond and second ticks
    nx.btn_prev = button_in;
    nx.held_ms = 13'(f_inc(14'(st.held_ms), `DLI_LIM_MS, ms_tick)); // R18
    nx.held_s = 8'(f_inc(14'(st.held_s), `DLI_LIM_S, s_tick));
    nx.rep_ms = 11'(f_inc(14'(st.rep_ms), `DLI_LIM_DBL, ms_tick));
    nx.dbl_ms = 11'(f_inc(14'(st.dbl_ms), `DLI_LIM_DBL, ms_tick));
    if (st.dbl_arm && st.dbl_ms > st.t_double)
    begin
      nx.dbl_arm = 1'b0; // R4
    end

    // Button classifier
    unique case (st.bst)
      dli_pkg::DLI_IDLE:
        if (press)
        begin
          ev[dli_pkg::DLI_EV_PRESS] = 1'b1; // R1
          nx.held_ms = '0;
          nx.held_s = '0;
          nx.bst = dli_pkg::DLI_HELD;
          if (!st.dbl_arm || st.dbl_ms > st.t_double)
          begin
            nx.dbl_ms = '0; // R4
          end
        end
      dli_pkg::DLI_HELD:
        if (rel)
        begin
          ev[dli_pkg::DLI_EV_RELEASE] = 1'b1; // R2
          ev[dli_pkg::DLI_EV_SHORT] = (st.held_ms < st.t_short); // R3
          nx.bst = dli_pkg::DLI_IDLE;
          if (st.dbl_arm && st.dbl_ms <= st.t_double)
          begin
            ev[dli_pkg::DLI_EV_DOUBLE] = 1'b1; // R4
            nx.dbl_arm = 1'b0;
          end
          else
          begin
            nx.dbl_arm = 1'b1;
          end
        end
        else if (st.held_ms >= st.t_short)
        begin
          ev[dli_pkg::DLI_EV_LSTART] = 1'b1; // R5
          nx.rep_ms = '0;
          nx.bst = dli_pkg::DLI_LONG;
        end
      dli_pkg::DLI_LONG:
        if (rel)
        begin
          ev[dli_pkg::DLI_EV_RELEASE] = 1'b1; // R2
          ev[dli_pkg::DLI_EV_LSTOP] = 1'b1; // R5
          nx.dbl_arm = 1'b0;
          nx.bst = dli_pkg::DLI_IDLE;
        end
        else if (st.ctrl[dli_pkg::DLI_EV_STUCK] && st.held_s > st.t_stuck)
        begin
          ev[dli_pkg::DLI_EV_STUCK] = 1'b1; // R7
          nx.bst = dli_pkg::DLI_STUCK;
        end
        else if (st.rep_ms >= st.t_rep)
        begin
          ev[dli_pkg::DLI_EV_LREPEAT] = 1'b1; // R6
          nx.rep_ms = '0;
        end
      dli_pkg::DLI_STUCK:
        if (rel)
        begin
          ev[dli_pkg::DLI_EV_RELEASE] = 1'b1; // R2
          ev[dli_pkg::DLI_EV_FREE] = 1'b1; // R7
          nx.dbl_arm = 1'b0;
          nx.bst = dli_pkg::DLI_IDLE;
        end
    endcase

    // Position: change or periodic report, then one dead-time slot
    nx.pos_prev = position_in;
    if (st.ctrl[dli_pkg::DLI_EV_POS])
    begin
      if (s_tick && st.t_prep != 8'h00)
      begin
        ptrig = (st.pos_rs >= st.t_prep - 8'h01); // R8
        nx.pos_rs = ptrig ? 8'h00 : st.pos_rs + 8'h01;
      end
      ptrig = ptrig | pchg;
    end
    // A trigger during a pending delay is merged: the report carries the latest value
    if (ptrig && !st.pos_pend)
    begin
      nx.pos_pend = 1'b1;
      nx.pos_dly = st.t_pdead; // R9
    end
    else if (st.pos_pend)
    begin
      if (st.pos_dly == 14'h0000)
      begin
        ev[dli_pkg::DLI_EV_POS] = 1'b1; // R9
        nx.pos_pend = 1'b0;
      end
      else
      begin
        nx.pos_dly = f_dn(st.pos_dly, ms_tick);
      end
    end

    // Occupancy: hold time gates a change; movement follows directly
    nx.occ_held = 12'(f_inc(14'(st.occ_held), `DLI_LIM_HOLD, s_tick)); // R12
    if (s_tick && st.t_orep != 8'h00)
    begin
      nx.orep_s = (st.orep_s >= st.t_orep - 8'h01) ? 8'h00 : st.orep_s + 8'h01;
    end
    // Strictly greater: the first second tick after a change may come at once
    if (occupied_in != st.occ && st.occ_held > st.t_hold)
    begin
      nx.occ = occupied_in; // R12
      nx.occ_held = '0;
      otrig = 1'b1;
      ocode = occupied_in ? dli_pkg::DLI_EV_OCC : dli_pkg::DLI_EV_VAC; // R10
    end
    else if (movement_in != st.mov)
    begin
      nx.mov = movement_in;
      otrig = 1'b1;
      ocode = movement_in ? dli_pkg::DLI_EV_MOVE : dli_pkg::DLI_EV_NOMOVE; // R11
    end
    else if (st.ctrl[`DLI_EN_OREP] && s_tick && st.t_orep != 8'h00 && st.orep_s >= st.t_orep - 8'h01)
    begin
      otrig = 1'b1; // R13
      ocode = st.occ ? dli_pkg::DLI_EV_OCC : dli_pkg::DLI_EV_VAC;
    end
    // Single slot: a newer event replaces a pending one and restarts the delay
    if (otrig)
    begin
      nx.o_pend = 1'b1;
      nx.o_code = ocode;
      nx.o_dly = st.t_odead; // R14
    end
    else if (st.o_pend)
    begin
      if (st.o_dly == 14'h0000)
      begin
        ev[st.o_code] = 1'b1; // R14
        nx.o_pend = 1'b0;
      end
      else
      begin
        nx.o_dly = f_dn(st.o_dly, ms_tick);
      end
    end

    // Instance test: first actuated input is latched until rearmed
    if (st.ident[`DLI_IDENT_TEST] && !st.inst_v)
    begin
      if (press)
      begin
        nx.inst = `DLI_INST_BTN; // R16
        nx.inst_v = 1'b1;
      end
      else if (pchg)
      begin
        nx.inst = `DLI_INST_POS; // R16
        nx.inst_v = 1'b1;
      end
      else if (occupied_in != st.occ)
      begin
        nx.inst = `DLI_INST_OCC; // R16
        nx.inst_v = 1'b1;
      end
    end

    // Avalon slave: one wait cycle, read data registered for the answer cycle
    nx.ack = busy & ~st.ack;
    if (avs_read_in && !st.ack)
    begin
      nx.rdata = f_rd(st, avs_address_in);
    end
    if (avs_write_in && take)
    begin
      case (avs_address_in)
        `DLI_REG_CTRL: nx.ctrl = 15'(f_wr(32'(st.ctrl), avs_writedata_in, avs_byteenable_in)) & `DLI_CTRL_MASK;
        `DLI_REG_T_SHORT: nx.t_short = 13'(f_wr(32'(st.t_short), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_DOUBLE: nx.t_double = 11'(f_wr(32'(st.t_double), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_REP: nx.t_rep = 11'(f_wr(32'(st.t_rep), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_STUCK: nx.t_stuck = 8'(f_wr(32'(st.t_stuck), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_PREP: nx.t_prep = 8'(f_wr(32'(st.t_prep), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_PDEAD: nx.t_pdead = 14'(f_wr(32'(st.t_pdead), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_HOLD: nx.t_hold = 12'(f_wr(32'(st.t_hold), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_OREP: nx.t_orep = 8'(f_wr(32'(st.t_orep), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_T_ODEAD: nx.t_odead = 14'(f_wr(32'(st.t_odead), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_STATUS: w1c = 14'(f_wr(32'h0000_0000, avs_writedata_in, avs_byteenable_in));
        `DLI_REG_MASK: nx.mask = 14'(f_wr(32'(st.mask), avs_writedata_in, avs_byteenable_in));
        `DLI_REG_IDENT:
        begin
          nx.ident = 2'(f_wr(32'(st.ident), avs_writedata_in, avs_byteenable_in)); // R15
          nx.inst_v = 1'b0;
        end
        default: nx.ident = st.ident;
      endcase
    end

    // Enable gating; a new event beats a write-one-to-clear in the same cycle
    gated = ev & f_en(st.ctrl); // R1 R2 R5 R10 R11
    nx.status = (st.status & ~w1c) | gated;
    nx.evt_v = |gated;
    nx.evt_c = f_first(gated);
  end

  // State register; reset leaves every timer idle and no event pending
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0; // R19
      st.t_short <= `DLI_RST_SHORT;
      st.t_double <= `DLI_RST_DOUBLE;
      st.t_rep <= `DLI_RST_REP;
      st.t_stuck <= `DLI_RST_STUCK;
      st.t_hold <= `DLI_RST_HOLD;
    end
    else
    begin
      st <= nx;
    end
  end

  assign avs_waitrequest_out = busy & ~st.ack;
  assign avs_readdata_out = st.rdata;
  assign irq_out = |(st.status & st.mask);
  assign identify_out = st.ident[`DLI_IDENT_ON]; // R15
  assign evt_valid_out = st.evt_v;
  assign evt_code_out = st.evt_c;

  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_press_event: assert property ((press && st.bst == dli_pkg::DLI_IDLE && st.ctrl[dli_pkg::DLI_EV_PRESS])
    |=> st.status[dli_pkg::DLI_EV_PRESS] && evt_valid_out && evt_code_out == 4'h0) // R1
    else $error("press event missing");
  a_release_mute: assert property ((rel && !st.ctrl[dli_pkg::DLI_EV_RELEASE] && !st.status[dli_pkg::DLI_EV_RELEASE])
    |=> !st.status[dli_pkg::DLI_EV_RELEASE]) // R2
    else $error("release event not suppressed");
  a_short_window: assert property (gated[dli_pkg::DLI_EV_SHORT] |-> rel && st.held_ms < st.t_short) // R3
    else $error("short press outside window");
  a_double_window: assert property (gated[dli_pkg::DLI_EV_DOUBLE] |-> st.dbl_arm && st.dbl_ms <= st.t_double) // R4
    else $error("double press outside window");
  a_long_stop: assert property ((rel && st.bst == dli_pkg::DLI_LONG && !st.ctrl[dli_pkg::DLI_EV_LSTOP]
    && !st.status[dli_pkg::DLI_EV_LSTOP]) |=> !st.status[dli_pkg::DLI_EV_LSTOP] && st.bst == dli_pkg::DLI_IDLE) // R5
    else $error("disabled long stop reported");
  a_repeat_period: assert property (ev[dli_pkg::DLI_EV_LREPEAT] |-> st.rep_ms >= st.t_rep ##1
    (st.rep_ms == 11'h000 && st.bst == dli_pkg::DLI_LONG)) // R6
    else $error("repeat period wrong");
  a_stuck_quiet: assert property (st.bst == dli_pkg::DLI_STUCK |-> !ev[dli_pkg::DLI_EV_LSTART]
    && !ev[dli_pkg::DLI_EV_LREPEAT] && !ev[dli_pkg::DLI_EV_LSTOP]) // R7
    else $error("long event while stuck");
  a_pos_dead: assert property (ev[dli_pkg::DLI_EV_POS] |-> st.pos_pend && st.pos_dly == 14'h0000) // R9
    else $error("position sent before dead time");
  a_occ_hold: assert property ((occupied_in != st.occ && st.occ_held <= st.t_hold) |=> $stable(st.occ)) // R12
    else $error("occupancy changed inside hold time");
  a_occ_dead: assert property ((st.o_pend && st.o_dly != 14'h0000 && !otrig) |-> !(|ev[13:10])) // R14
    else $error("occupancy sent before dead time");
  a_set_wins: assert property ((take && avs_write_in && avs_address_in == `DLI_REG_STATUS && |gated)
    |=> (st.status & $past(gated)) == $past(gated))
    else $error("event lost to status clear");
  a_bus_answer: assert property ((busy && !st.ack) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus answer not after one wait cycle");
endmodule

// ===== verilog/dli_pkg.sv
`include "dli_defs.svh"
package dli_pkg;
  typedef enum logic [1:0] {DLI_IDLE = 2'b00, DLI_HELD = 2'b01, DLI_LONG = 2'b10, DLI_STUCK = 2'b11} dli_btn_type;
  typedef enum logic [3:0] {
    DLI_EV_PRESS = 4'h0, DLI_EV_RELEASE = 4'h1, DLI_EV_SHORT = 4'h2, DLI_EV_DOUBLE = 4'h3,
    DLI_EV_LSTART = 4'h4, DLI_EV_LREPEAT = 4'h5, DLI_EV_LSTOP = 4'h6, DLI_EV_STUCK = 4'h7,
    DLI_EV_FREE = 4'h8, DLI_EV_POS = 4'h9, DLI_EV_OCC = 4'ha, DLI_EV_VAC = 4'hb,
    DLI_EV_MOVE = 4'hc, DLI_EV_NOMOVE = 4'hd
  } dli_event_type;
  typedef struct packed {
    logic [`DLI_DIV_W-1:0] div;
    logic [9:0] ms;
    logic ms_t;
    logic s_t;
  } dli_tick_type;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [14:0] ctrl;
    logic [12:0] t_short;
    logic [10:0] t_double;
    logic [10:0] t_rep;
    logic [7:0] t_stuck;
    logic [7:0] t_prep;
    logic [13:0] t_pdead;
    logic [11:0] t_hold;
    logic [7:0] t_orep;
    logic [13:0] t_odead;
    logic [13:0] status;
    logic [13:0] mask;
    logic [1:0] ident;
    logic [1:0] inst;
    logic inst_v;
    logic btn_prev;
    dli_btn_type bst;
    logic [12:0] held_ms;
    logic [7:0] held_s;
    logic [10:0] rep_ms;
    logic dbl_arm;
    logic [10:0] dbl_ms;
    logic [7:0] pos_prev;
    logic [7:0] pos_rs;
    logic pos_pend;
    logic [13:0] pos_dly;
    logic occ;
    logic [11:0] occ_held;
    logic mov;
    logic [7:0] orep_s;
    logic o_pend;
    dli_event_type o_code;
    logic [13:0] o_dly;
    logic evt_v;
    logic [3:0] evt_c;
  } dli_core_type;
endpackage

// ===== verilog/dli_tick.sv
`include "dli_defs.svh"
// Millisecond and second enables shared by every timer of the block
module dli_tick #(
  parameter int CYC_PER_MS = `DLI_CYC_PER_MS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  output logic ms_tick_out,
  output logic s_tick_out
);
  dli_pkg::dli_tick_type st;
  dli_pkg::dli_tick_type nx;
  logic wrap;

  // Divider chain; the second tick coincides with a millisecond tick
  always_comb
  begin
    nx = st;
    wrap = (st.div == `DLI_DIV_W'(CYC_PER_MS - 1));
    nx.div = wrap ? '0 : st.div + `DLI_DIV_W'(1);
    nx.ms_t = wrap;
    nx.s_t = wrap && (st.ms == `DLI_MS_PER_S - 10'h001);
    if (wrap)
    begin
      nx.ms = nx.s_t ? 10'h000 : st.ms + 10'h001;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign ms_tick_out = st.ms_t;
  assign s_tick_out = st.s_t;
endmodule
